//--- src/np_gig_regs.sv
// Added by the designer: the APB interface to the registers.
`include "np_gig_consts.svh"

module np_gig_regs
	import np_gig_pkg::*;
#(
	parameter bit FD_FROM_STRAP = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        np_load,
	input  wire next_page_t  np_word,
	input  wire logic        fd_strap,
	input  wire logic        link_up,
	output gig_cfg_t         cfg,
	output logic             tdr_start
);

	localparam logic [15:0] NPR_RST  = `NPR_RESET;
	localparam logic [15:0] GCFG_RST = `GCFG_RESET;

	// the strap is only trusted once both synchroniser stages hold it
	typedef enum logic [1:0] {
		STRAP_FILL = 2'b00,
		STRAP_ARM  = 2'b01,
		STRAP_TAKE = 2'b10,
		STRAP_DONE = 2'b11
	} strap_state_t;

	logic            more_q;
	logic            ack_q;
	logic            msg_q;
	logic            comply_q;
	logic            toggle_q;
	logic [10:0]     code_q;
	next_page_t      npr_view;

	logic [2:0]      test_q;
	logic            force_q;
	logic            master_q;
	logic            port_q;
	logic            fd_q;
	logic            hd_q;
	logic            tdr_q;
	logic [15:0]     gcfg_view;

	logic [1:0]      pin_in;
	wire logic [1:0] pin_sync;
	logic            link_prev_q;
	logic            link_fall;
	strap_state_t    strap_q;
	strap_state_t    strap_d;

	logic            access;
	logic            sel_npr;
	logic            sel_gcfg;
	logic            mapped;
	logic            wr_npr;
	logic            wr_gcfg;
	logic [15:0]     wdata;
	logic [15:0]     wmask;
	logic [15:0]     npr_wen;
	logic [15:0]     gcfg_wen;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
		hit = (a == ref_a);
	endfunction

	// per-bit write enable: decoded write, byte lane and writable mask together
	function automatic logic [15:0] bit_wen(
		input logic        wr,
		input logic [15:0] lanes,
		input logic [15:0] rw_mask
	);
		bit_wen = {16{wr}} & lanes & rw_mask;
	endfunction

	// pready is registered, so each access phase lasts two cycles
	assign access    = psel & penable & ~pready;
	assign sel_npr   = hit(paddr, `NPR_ADDR);
	assign sel_gcfg  = hit(paddr, `GCFG_ADDR);
	assign mapped    = sel_npr | sel_gcfg;
	assign wr_npr    = access & pwrite & sel_npr;
	assign wr_gcfg   = access & pwrite & sel_gcfg;
	assign wdata     = pwdata[15:0];
	assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign npr_wen   = bit_wen(wr_npr, wmask, `NPR_RW_MASK);
	assign gcfg_wen  = bit_wen(wr_gcfg, wmask, `GCFG_WR_MASK);

	assign npr_view  = '{more_q, ack_q, msg_q, comply_q, toggle_q, code_q};
	assign gcfg_view = {test_q, force_q, master_q, port_q, fd_q, hd_q, tdr_q, 7'h00};

	assign pin_in    = {link_up, fd_strap};

	// both pins come from outside the clock domain, so two flops each
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			logic s1_q;
			logic s2_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
				end else begin
					s1_q <= pin_in[gi];
					s2_q <= s1_q;
				end
			end
			assign pin_sync[gi] = s2_q;
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= access;
		end
	end

	// unmapped offsets are refused and nothing is written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= access & ~mapped;
		end
	end

	// cleared on writes, so a stale read word never rides a later pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (access) begin
			if (pwrite) begin
				prdata <= 32'h0000_0000;
			end else if (sel_npr) begin
				prdata <= {16'h0000, npr_view};
			end else if (sel_gcfg) begin
				prdata <= {16'h0000, gcfg_view};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// received page: a hardware load beats a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			more_q <= NPR_RST[`NPR_MORE_BIT];
		end else if (np_load) begin
			more_q <= np_word.more_pages_flag;
		end else if (npr_wen[`NPR_MORE_BIT]) begin
			more_q <= wdata[`NPR_MORE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= NPR_RST[`NPR_ACK_BIT];
		end else if (np_load) begin
			ack_q <= np_word.ack;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_q <= NPR_RST[`NPR_MSG_BIT];
		end else if (np_load) begin
			msg_q <= np_word.message_page_flag;
		end else if (npr_wen[`NPR_MSG_BIT]) begin
			msg_q <= wdata[`NPR_MSG_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comply_q <= NPR_RST[`NPR_COMPLY_BIT];
		end else if (np_load) begin
			comply_q <= np_word.partner_can_comply;
		end else if (npr_wen[`NPR_COMPLY_BIT]) begin
			comply_q <= wdata[`NPR_COMPLY_BIT];
		end
	end

	// read-only: always the opposite of the toggle in the word just exchanged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_q <= NPR_RST[`NPR_TOGGLE_BIT];
		end else if (np_load) begin
			toggle_q <= ~np_word.page_toggle;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_q <= NPR_RST[10:0];
		end else if (np_load) begin
			code_q <= np_word.code;
		end else if (|npr_wen[10:0]) begin
			code_q <= (code_q & ~npr_wen[10:0]) | (wdata[10:0] & npr_wen[10:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_q <= GCFG_RST[15:13];
		end else if (|gcfg_wen[15:13]) begin
			test_q <= (test_q & ~gcfg_wen[15:13]) | (wdata[15:13] & gcfg_wen[15:13]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_q <= GCFG_RST[`GCFG_FORCE_BIT];
		end else if (gcfg_wen[`GCFG_FORCE_BIT]) begin
			force_q <= wdata[`GCFG_FORCE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_q <= GCFG_RST[`GCFG_MASTER_BIT];
		end else if (gcfg_wen[`GCFG_MASTER_BIT]) begin
			master_q <= wdata[`GCFG_MASTER_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_q <= GCFG_RST[`GCFG_PORT_BIT];
		end else if (gcfg_wen[`GCFG_PORT_BIT]) begin
			port_q <= wdata[`GCFG_PORT_BIT];
		end
	end

	// software always wins over the strap, even while capture is pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fd_q <= GCFG_RST[`GCFG_FD_BIT];
		end else if (gcfg_wen[`GCFG_FD_BIT]) begin
			fd_q <= wdata[`GCFG_FD_BIT];
		end else if (FD_FROM_STRAP && strap_q == STRAP_TAKE) begin
			fd_q <= pin_sync[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hd_q <= GCFG_RST[`GCFG_HD_BIT];
		end else if (gcfg_wen[`GCFG_HD_BIT]) begin
			hd_q <= wdata[`GCFG_HD_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdr_q <= GCFG_RST[`GCFG_TDR_BIT];
		end else if (gcfg_wen[`GCFG_TDR_BIT]) begin
			tdr_q <= wdata[`GCFG_TDR_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q <= STRAP_FILL;
		end else begin
			strap_q <= strap_d;
		end
	end

	always_comb begin
		strap_d = strap_q;
		case (strap_q)
			STRAP_FILL: strap_d = STRAP_ARM;
			STRAP_ARM:  strap_d = STRAP_TAKE;
			STRAP_TAKE: strap_d = STRAP_DONE;
			STRAP_DONE: strap_d = STRAP_DONE;
			default:    strap_d = STRAP_DONE;
		endcase
		// a software write settles bit 9 for good
		if (wr_gcfg) begin
			strap_d = STRAP_DONE;
		end
	end

	// the role bit only means master while forcing is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= gig_cfg_t'({3'b000, 6'b000110});
		end else begin
			cfg.test_mode    <= test_mode_t'(test_q);
			cfg.force_role   <= force_q;
			cfg.force_master <= force_q & master_q;
			cfg.multi_port   <= port_q;
			cfg.adv_full     <= fd_q;
			cfg.adv_half     <= hd_q;
			cfg.tdr_auto     <= tdr_q;
		end
	end

	// previous level resets low, so a pin already high gives no false fall
	assign link_fall = link_prev_q & ~pin_sync[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_prev_q <= 1'b0;
		end else begin
			link_prev_q <= pin_sync[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdr_start <= 1'b0;
		end else begin
			tdr_start <= tdr_q & link_fall;
		end
	end

endmodule

//--- pkg/np_gig_consts.svh
`ifndef NP_GIG_CONSTS_SVH
`define NP_GIG_CONSTS_SVH

`define NPR_INDEX          4'h8
`define GCFG_INDEX         4'h9
`define NPR_ADDR           12'h020
`define GCFG_ADDR          12'h024

`define NPR_MORE_BIT       15
`define NPR_ACK_BIT        14
`define NPR_MSG_BIT        13
`define NPR_COMPLY_BIT     12
`define NPR_TOGGLE_BIT     11

`define NPR_RESET          16'h2001
`define NPR_RW_MASK        16'hB7FF
`define NPR_CODE_RESET     11'h001

`define GCFG_FORCE_BIT     12
`define GCFG_MASTER_BIT    11
`define GCFG_PORT_BIT      10
`define GCFG_FD_BIT        9
`define GCFG_HD_BIT        8
`define GCFG_TDR_BIT       7
`define GCFG_WR_MASK       16'hFF80
`define GCFG_RESET         16'h0300

`endif

//--- pkg/np_gig_pkg.sv
package np_gig_pkg;

	typedef enum logic [2:0] {
		TEST_NORMAL   = 3'b000,
		TEST_WAVEFORM = 3'b001,
		TEST_JIT_MST  = 3'b010,
		TEST_JIT_SLV  = 3'b011,
		TEST_DISTORT  = 3'b100,
		TEST_SCR_IDLE = 3'b101,
		TEST_REP_0001 = 3'b110,
		TEST_PULSE_63 = 3'b111
	} test_mode_t;

	typedef struct packed {
		logic        more_pages_flag;
		logic        ack;
		logic        message_page_flag;
		logic        partner_can_comply;
		logic        page_toggle;
		logic [10:0] code;
	} next_page_t;

	typedef struct packed {
		test_mode_t test_mode;
		logic       force_role;
		logic       force_master;
		logic       multi_port;
		logic       adv_full;
		logic       adv_half;
		logic       tdr_auto;
	} gig_cfg_t;

endpackage

//--- dv/np_gig_regs_sva.sv
`include "np_gig_consts.svh"
module np_gig_regs_sva
	import np_gig_pkg::*;
(
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        link_up,
	input gig_cfg_t    cfg,
	input logic        tdr_start
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] wd_q;
	// last bus data word of any access, read or write, held until the config copy has caught up
	always_ff @(posedge pclk) begin
		if (psel && penable) begin
			wd_q <= pwdata[15:0];
		end
	end
	sequence cfg_wr;
		pready && pwrite && paddr == `GCFG_ADDR;
	endsequence
	sequence cfg_rd;
		pready && !pwrite && paddr == `GCFG_ADDR;
	endsequence
	wait_state_a: assert property (psel && !penable |-> ##2 pready) else $error("late pready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	refuse_a: assert property (pready && paddr != `NPR_ADDR && paddr != `GCFG_ADDR
		|-> pslverr && prdata == 32'h0) else $error("no refusal");
	mapped_ok_a: assert property (pready && (paddr == `NPR_ADDR || paddr == `GCFG_ADDR)
		|-> !pslverr) else $error("false refusal");
	cfg_write_a: assert property (cfg_wr |-> ##2
		cfg == {wd_q[15:12], wd_q[12] & wd_q[11], wd_q[10:7]})
		else $error("config not taken");
	cfg_read_a: assert property (cfg_rd |-> prdata[31:16] == 16'h0000
		&& prdata[15:12] == {cfg.test_mode, cfg.force_role}
		&& prdata[10:7] == {cfg.multi_port, cfg.adv_full, cfg.adv_half, cfg.tdr_auto}
		&& cfg.force_master == (prdata[12] && prdata[11]))
		else $error("config readback");
	rsvd_zero_a: assert property (cfg_rd |-> prdata[6:0] == 7'h00)
		else $error("reserved bits set");
	// the pin is synchronised first, so a short window is allowed
	tdr_launch_a: assert property (cfg.tdr_auto && $fell(link_up) |-> ##[1:8] tdr_start)
		else $error("no diagnostic");
endmodule
bind np_gig_regs np_gig_regs_sva np_gig_regs_sva_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up, .cfg, .tdr_start);

//--- dv/np_gig_regs_tb.sv
`include "np_gig_consts.svh"
module np_gig_regs_tb import np_gig_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        np_load = 0, link_up = 1, pready, pslverr, tdr_start;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, n;
	logic [15:0] w [2] = '{16'hD555, 16'h4000};
	next_page_t  np_word = 0;
	gig_cfg_t    cfg;
	int          fail_count, compares, cyc;
	always #2.5 pclk = ~pclk;
	np_gig_regs np_gig_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'h3), .prdata, .pready, .pslverr, .np_load, .np_word, .fd_strap(1'b0),
		.link_up, .cfg, .tdr_start);
	task automatic chk(input logic [31:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one apb transfer; the trailing edge keeps psel from being assigned twice
	task automatic op(input logic wr, input logic [11:0] a, input logic [31:0] d, exp,
		input logic err);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		chk(pslverr, err, "pslverr");
		if (!wr) chk(prdata, exp, "prdata");
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		op(0, `NPR_ADDR, 0, 32'h2001, 0);
		op(0, `GCFG_ADDR, 0, 32'h0300, 0);
		chk(cfg, 32'h6, "cfg");
		foreach (w[i]) begin
			np_word <= w[i];
			np_load <= 1;
			@(posedge pclk);
			np_load <= 0;
			@(posedge pclk);
			op(0, `NPR_ADDR, 0, w[i] ^ 32'h0800, 0);
		end
		op(1, `NPR_ADDR, 32'h0, 0, 0);
		op(0, `NPR_ADDR, 0, 32'h4800, 0);
		op(1, `NPR_ADDR, 32'hFFFF, 0, 0);
		op(0, `NPR_ADDR, 0, 32'hFFFF, 0);
		for (int i = 0; i < 8; i++) begin
			q = 32'hFFFF007F | (i << 13) | (i[0] ? 32'h1F80 : 32'h0800);
			op(1, `GCFG_ADDR, q, 0, 0);
			op(0, `GCFG_ADDR, 0, q & 32'hFF80, 0);
			chk(cfg, {q[15:12], q[12] & q[11], q[10:7]}, "cfg");
		end
		op(0, 12'h028, 0, 0, 1);
		op(1, 12'h000, 0, 0, 1);
		op(0, `GCFG_ADDR, 0, 32'hFF80, 0);
		for (int k = 0; k < 2; k++) begin
			op(1, `GCFG_ADDR, k << 7, 0, 0);
			link_up <= 1;
			repeat (8) @(posedge pclk);
			link_up <= 0;
			n = 0;
			repeat (12) begin
				@(posedge pclk);
				n += tdr_start;
			end
			chk(n, k, "tdr_start");
		end
		conclude();
	end
endmodule
